//--- src/agpe_pkg.sv
// Constants shared by the general-purpose event and power-level logic
package agpe_pkg;

  // Host I/O bus widths
  localparam int          IO_AW         = 16;
  localparam int          IO_DW         = 8;

  // Event block offsets from its base
  localparam logic [15:0] OFS_STS_LO    = 16'h0000;
  localparam logic [15:0] OFS_STS_HI    = 16'h0001;
  localparam logic [15:0] OFS_EN_LO     = 16'h0002;
  localparam logic [15:0] OFS_EN_HI     = 16'h0003;
  localparam logic [15:0] GPE_SPAN      = 16'h0008;

  // Power-level triggers, offsets from the processor control block base
  localparam logic [15:0] OFS_C2_TRIG   = 16'h0004;
  localparam logic [15:0] OFS_C3_TRIG   = 16'h0005;

  // Bit positions in the low status and enable bytes
  localparam int          BIT_LID       = 7;
  localparam int          BIT_EC        = 6;
  localparam int          BIT_USB       = 5;
  localparam int          BIT_RING      = 4;
  localparam int          BIT_RING2     = 3;
  localparam int          BIT_CARD      = 2;
  localparam int          BIT_REQ_IN_N_A      = 1;
  localparam int          BIT_REQ_IN_N_B    = 0;

  // Bit positions in the high status and enable bytes
  localparam int          BIT_THERM     = 4;
  localparam int          BIT_FW_REQ    = 7;
  localparam int          SPARE_N       = 4;
  localparam int          HI_W          = 5;

  // Synchronised event inputs: eight low-byte sources plus the spares
  localparam int          EVT_N         = 12;
  localparam logic [1:0]  WARM_DONE     = 2'h3;

  // Reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [4:0]  RST_HI        = 5'h00;
  localparam logic [2:0]  HI_PAD        = 3'h0;

endpackage : agpe_pkg

//--- src/agpe_edge_sync.sv
// Two-flop synchroniser with falling and any-edge detection per input
module agpe_edge_sync
  import agpe_pkg::*;
#(
  parameter int WIDTH = agpe_pkg::EVT_N
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] fall_pulse,
  output logic      [WIDTH-1:0] any_pulse
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] fall;
    logic [WIDTH-1:0] any;
    logic [1:0]       warm;
  } agpe_sync_t;

  agpe_sync_t q;
  agpe_sync_t next_q;

  // Edges are held off until the chain has filled, so reset gives no false event
  always_comb begin
    next_q      = q;
    next_q.meta = async_in;
    next_q.sync = q.meta;
    next_q.prev = q.sync;
    if (q.warm != WARM_DONE) begin
      next_q.warm = q.warm + 2'h1;
    end
    for (int i = 0; i < WIDTH; i++) begin
      next_q.fall[i] = (q.warm == WARM_DONE) && q.prev[i] && !q.sync[i];
      next_q.any[i]  = (q.warm == WARM_DONE) && (q.prev[i] != q.sync[i]);
    end
  end

  // Idle level of the active-low lines is high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '{meta: '1, sync: '1, prev: '1, fall: '0, any: '0, warm: 2'h0};
    end else begin
      q <= next_q;
    end
  end

  assign fall_pulse = q.fall;
  assign any_pulse  = q.any;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  fall_once_a: assert property (q.fall != '0 |=> (q.fall & $past(q.fall)) == '0)
    else $error("falling edge reported twice");

endmodule : agpe_edge_sync

//--- src/agpe_block.sv
// General-purpose event status/enable bytes and power-level read triggers
// Function
// - Reading the C2 trigger byte forces clock control into C2; writes ignored.
// - Reading the C3 trigger byte forces clock control into C3; writes ignored.
// - The C2 trigger acts exactly like the doze-mode control bit.
// - The C3 trigger acts exactly like the zero-volt suspend control bit.
// - Event block decoded as byte offsets from a software-programmed base.
// - Lid activity in either direction sets status bit 7; write 1 clears.
// - Embedded-controller event low sets status bit 6 until written 1.
// - USB wake low sets status bit 5; write 1 clears.
// - Ring input low, pin or drive-back, sets status bit 4; write 1 clears.
// - Second ring low, pin or drive-back, sets status bit 3; write 1 clears.
// - Card status-change low sets status bit 2; write 1 clears.
// - Req_in_n_a low sets bit 1, req_in_n_b low sets bit 0; write 1 clears.
// - Toggle of the selected thermal counter bit sets high status bit 4.
// - Each spare input going low sets its high status bit; write 1 clears.
// - Low enable bits gate low status bits onto the control interrupt.
// - High enable bit 4 gates the thermal status onto the interrupt.
// - High enable bits 3..0 gate the spare status bits onto the interrupt.
// - High enable bit 7 is write-only firmware request; reads return zero.
// - Event block offsets 04h to 07h are reserved with no function.
// - Firmware request write sets the global service flag elsewhere.
// - Control interrupt goes out as SMI when route is 0, IRQ13 when 1.
module agpe_block
  import agpe_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // Host I/O access
  input  wire logic [agpe_pkg::IO_AW-1:0]    io_addr,
  input  wire logic                          io_rd,
  input  wire logic                          io_wr,
  input  wire logic [agpe_pkg::IO_DW-1:0]    io_wdata,
  output logic      [agpe_pkg::IO_DW-1:0]    io_rdata,
  output logic                               io_claim,
  // Bases programmed in the second PCI function
  input  wire logic [agpe_pkg::IO_AW-1:0]    gp_event_block_base,
  input  wire logic [agpe_pkg::IO_AW-1:0]    processor_control_block_base,
  // Event sources
  input  wire logic                          lid_in,
  input  wire logic                          ec_event_in_n,
  input  wire logic                          usb_wake_in_n,
  input  wire logic                          ring_in_n,
  input  wire logic                          ring_driveback_n,
  input  wire logic                          second_ring_in_n,
  input  wire logic                          second_ring_driveback_n,
  input  wire logic                          card_change_in_n,
  input  wire logic                          req_in_n_a,
  input  wire logic                          req_in_n_b,
  input  wire logic [agpe_pkg::SPARE_N-1:0]  spare_in_n,
  // Thermal counter and its bit select, same clock domain
  input  wire logic [15:0]                   thermal_freq_counter,
  input  wire logic [3:0]                    thermal_group_select,
  // Delivery select for the control interrupt
  input  wire logic                          interrupt_route_select,
  // Outputs to clock control and interrupt logic
  output logic                               force_c2_pulse,
  output logic                               force_c3_pulse,
  output logic                               global_service_set,
  output logic                               sci_smi,
  output logic                               sci_irq13
);

  typedef struct packed {
    logic [7:0]         sts_lo;
    logic [SPARE_N-1:0] sts_spare;
    logic               sts_therm;
    logic [7:0]         en_lo;
    logic [HI_W-1:0]    en_hi;
    logic               therm_prev;
    logic [3:0]         sel_prev;
    logic               therm_armed;
    logic [7:0]         rdata;
    logic               claim;
    logic               c2;
    logic               c3;
    logic               fw_req;
    logic               smi;
    logic               irq13;
  } agpe_state_t;

  agpe_state_t q;
  agpe_state_t next_q;

  logic [EVT_N-1:0] evt_raw;
  logic [EVT_N-1:0] evt_fall;
  logic [EVT_N-1:0] evt_any;
  logic [15:0]      gpe_off;
  logic [15:0]      pblk_off;
  logic             gpe_hit;
  logic             c2_hit;
  logic             c3_hit;
  logic [7:0]       set_lo;
  logic [7:0]       clr_lo;
  logic [7:0]       clr_hi;
  logic             therm_bit;
  logic             therm_toggle;
  logic             pending;

  // Pin and drive-back sources share a line: either pulled low is activity
  always_comb begin
    evt_raw             = '1;
    evt_raw[BIT_LID]    = lid_in;
    evt_raw[BIT_EC]     = ec_event_in_n;
    evt_raw[BIT_USB]    = usb_wake_in_n;
    evt_raw[BIT_RING]   = ring_in_n & ring_driveback_n;
    evt_raw[BIT_RING2]  = second_ring_in_n & second_ring_driveback_n;
    evt_raw[BIT_CARD]   = card_change_in_n;
    evt_raw[BIT_REQ_IN_N_A]   = req_in_n_a;
    evt_raw[BIT_REQ_IN_N_B] = req_in_n_b;
    evt_raw[EVT_N-1:8]  = spare_in_n;
  end

  // Every pin source crosses in through two flops before any edge is seen; the thermal counter does not
  agpe_edge_sync #(
    .WIDTH      (EVT_N)
  ) u_sync (
    .core_clk   (core_clk),
    .srst       (srst),
    .async_in   (evt_raw),
    .fall_pulse (evt_fall),
    .any_pulse  (evt_any)
  );

  // Address decode; subtraction lets the bases sit on any byte boundary
  always_comb begin
    gpe_off  = io_addr - gp_event_block_base;
    pblk_off = io_addr - processor_control_block_base;
    gpe_hit  = gpe_off < GPE_SPAN;
    c2_hit   = pblk_off == OFS_C2_TRIG;
    c3_hit   = pblk_off == OFS_C3_TRIG;
  end

  // Event sets: lid counts both directions, the rest only going low
  always_comb begin
    set_lo          = evt_fall[7:0];
    set_lo[BIT_LID] = evt_any[BIT_LID];
  end

  // A select change would look like a toggle, so it is ignored for a cycle
  always_comb begin
    therm_bit    = thermal_freq_counter[thermal_group_select];
    // The remembered bit is reset to zero, not to the counter, so the first cycle is skipped
    therm_toggle = q.therm_armed
                   && (thermal_group_select == q.sel_prev)
                   && (therm_bit != q.therm_prev);
  end

  // Write-one-to-clear masks, only for a write that hits the byte
  always_comb begin
    clr_lo = '0;
    clr_hi = '0;
    if (io_wr && gpe_hit && gpe_off == OFS_STS_LO) begin
      clr_lo = io_wdata;
    end
    if (io_wr && gpe_hit && gpe_off == OFS_STS_HI) begin
      clr_hi = io_wdata;
    end
  end

  // Any enabled status raises the control interrupt
  always_comb begin
    pending = |(q.sts_lo & q.en_lo)
              | (q.sts_therm & q.en_hi[BIT_THERM])
              | |(q.sts_spare & q.en_hi[SPARE_N-1:0]);
  end

  // Next-state: set wins over a clear in the same cycle
  always_comb begin
    next_q            = q;
    next_q.c2         = 1'b0;
    next_q.c3         = 1'b0;
    next_q.fw_req     = 1'b0;
    next_q.claim      = 1'b0;
    next_q.therm_prev = therm_bit;
    next_q.sel_prev   = thermal_group_select;
    next_q.therm_armed = 1'b1;

    // Status bytes
    next_q.sts_lo    = (q.sts_lo & ~clr_lo) | set_lo;
    next_q.sts_spare = (q.sts_spare & ~clr_hi[SPARE_N-1:0])
                       | evt_fall[EVT_N-1:8];
    next_q.sts_therm = (q.sts_therm & ~clr_hi[BIT_THERM])
                       | therm_toggle;

    // Enable writes; reserved high bits are dropped
    if (io_wr && gpe_hit) begin
      next_q.claim = 1'b1;
      case (gpe_off)
        OFS_EN_LO: begin
          next_q.en_lo = io_wdata;
        end
        OFS_EN_HI: begin
          next_q.en_hi  = io_wdata[HI_W-1:0];
          next_q.fw_req = io_wdata[BIT_FW_REQ];
        end
        default: begin
          next_q.claim = 1'b1;
        end
      endcase
    end

    // Trigger bytes only claim a write, they never act on it
    if (io_wr && (c2_hit || c3_hit)) begin
      next_q.claim = 1'b1;
    end

    // Reads: data is registered, trigger reads also return zero
    if (io_rd) begin
      next_q.rdata = RST_BYTE;
      if (gpe_hit) begin
        next_q.claim = 1'b1;
        case (gpe_off)
          OFS_STS_LO: begin
            next_q.rdata = q.sts_lo;
          end
          OFS_STS_HI: begin
            next_q.rdata = {HI_PAD, q.sts_therm, q.sts_spare};
          end
          OFS_EN_LO: begin
            next_q.rdata = q.en_lo;
          end
          OFS_EN_HI: begin
            next_q.rdata = {HI_PAD, q.en_hi};
          end
          default: begin
            next_q.rdata = RST_BYTE;
          end
        endcase
      end
      if (c2_hit) begin
        next_q.claim = 1'b1;
        next_q.c2    = 1'b1;
      end
      if (c3_hit) begin
        next_q.claim = 1'b1;
        next_q.c3    = 1'b1;
      end
    end

    // Interrupt delivery, one path only
    next_q.smi   = pending && !interrupt_route_select;
    next_q.irq13 = pending && interrupt_route_select;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '{sts_lo: RST_BYTE, sts_spare: '0, sts_therm: 1'b0,
             en_lo: RST_BYTE, en_hi: RST_HI, therm_prev: 1'b0,
             sel_prev: 4'h0, therm_armed: 1'b0, rdata: RST_BYTE, claim: 1'b0,
             c2: 1'b0, c3: 1'b0, fw_req: 1'b0, smi: 1'b0, irq13: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign io_rdata           = q.rdata;
  assign io_claim           = q.claim;
  assign force_c2_pulse     = q.c2;
  assign force_c3_pulse     = q.c3;
  assign global_service_set = q.fw_req;
  assign sci_smi            = q.smi;
  assign sci_irq13          = q.irq13;

  // Checks on the outputs against their causes
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  c2_read_trig_a: assert property (io_rd && c2_hit |=> force_c2_pulse)
    else $error("C2 trigger read did not force C2");

  c2_no_write_a: assert property (force_c2_pulse |-> $past(io_rd))
    else $error("C2 forced without a read");

  c3_read_trig_a: assert property (io_rd && c3_hit |=> force_c3_pulse)
    else $error("C3 trigger read did not force C3");

  c3_no_write_a: assert property (force_c3_pulse |-> $past(io_rd))
    else $error("C3 forced without a read");

  gpe_base_dec_a: assert property (
    io_rd && gpe_hit && gpe_off == OFS_EN_LO |=> io_rdata == $past(q.en_lo))
    else $error("enable byte read wrong through base");

  lid_sets_a: assert property (
    evt_any[BIT_LID] ##1 1'b1 |-> q.sts_lo[BIT_LID])
    else $error("lid activity lost");

  ec_sticky_a: assert property (
    q.sts_lo[BIT_EC] && clr_lo[BIT_EC] == 1'b0 |=> q.sts_lo[BIT_EC])
    else $error("embedded controller flag dropped");

  usb_w1c_a: assert property (
    q.sts_lo[BIT_USB] && clr_lo[BIT_USB] && !set_lo[BIT_USB]
    |=> !q.sts_lo[BIT_USB])
    else $error("USB wake flag not cleared");

  ring_set_a: assert property (evt_fall[BIT_RING] |=> q.sts_lo[BIT_RING])
    else $error("ring flag not set");

  ring2_set_a: assert property (evt_fall[BIT_RING2] |=> q.sts_lo[BIT_RING2])
    else $error("second ring flag not set");

  card_set_a: assert property (evt_fall[BIT_CARD] |=> q.sts_lo[BIT_CARD])
    else $error("card change flag not set");

  req_in_n_a_pair_a: assert property (
    evt_fall[BIT_REQ_IN_N_A] && evt_fall[BIT_REQ_IN_N_B]
    |=> q.sts_lo[BIT_REQ_IN_N_A] && q.sts_lo[BIT_REQ_IN_N_B])
    else $error("req_in_n_a or req_in_n_b flag not set");

  therm_set_a: assert property (therm_toggle |=> q.sts_therm)
    else $error("thermal toggle lost");

  spare_set_a: assert property (
    evt_fall[EVT_N-1:8] != '0 |=> (q.sts_spare & $past(evt_fall[EVT_N-1:8]))
    == $past(evt_fall[EVT_N-1:8]))
    else $error("spare flag not set");

  lo_gate_a: assert property (
    (q.sts_lo & q.en_lo) != '0 |=> sci_smi || sci_irq13)
    else $error("enabled low event raised no interrupt");

  therm_gate_a: assert property (
    q.sts_therm && !q.en_hi[BIT_THERM] && (q.sts_lo & q.en_lo) == '0
    && (q.sts_spare & q.en_hi[SPARE_N-1:0]) == '0 |=> !sci_smi && !sci_irq13)
    else $error("masked thermal event raised interrupt");

  spare_gate_a: assert property (
    (q.sts_spare & q.en_hi[SPARE_N-1:0]) != '0 |=> sci_smi || sci_irq13)
    else $error("enabled spare event raised no interrupt");

  fw_req_rd0_a: assert property (
    io_rd && gpe_hit && gpe_off == OFS_EN_HI |=> io_rdata[BIT_FW_REQ] == 1'b0)
    else $error("firmware request bit read back nonzero");

  fw_req_set_a: assert property (
    io_wr && gpe_hit && gpe_off == OFS_EN_HI && io_wdata[BIT_FW_REQ]
    |=> global_service_set ##1 !global_service_set)
    else $error("firmware request not a single pulse");

  resv_read_a: assert property (
    io_rd && gpe_hit && gpe_off > OFS_EN_HI |=> io_rdata == RST_BYTE)
    else $error("reserved offset read nonzero");

  resv_bits_a: assert property (
    io_rd && gpe_hit && gpe_off == OFS_STS_HI |=> io_rdata[7:5] == HI_PAD)
    else $error("reserved status bits read nonzero");

  route_excl_a: assert property (
    pending |=> (sci_irq13 == $past(interrupt_route_select))
    && (sci_smi == !$past(interrupt_route_select)))
    else $error("interrupt delivered on wrong path");

  // Main scenarios
  cov_c2_read_c: cover property (io_rd && c2_hit ##1 force_c2_pulse);
  cov_set_clear_c: cover property (set_lo[BIT_REQ_IN_N_A] && clr_lo[BIT_REQ_IN_N_A]);
  cov_irq13_c: cover property (sci_irq13);
  cov_therm_c: cover property (therm_toggle ##1 q.sts_therm);

endmodule : agpe_block

//--- dv/agpe_event_src.sv
// Model of the external event sources: docking, card and embedded controllers
module agpe_event_src (
  input  wire logic        core_clk,
  input  wire logic [13:0] pulse_req,
  output logic             lid_in,
  output logic      [13:0] pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] left [14];

  initial begin
    lid_in = 1'b1;
    foreach (left[i]) left[i] = 3'h0;
  end

  // Each request holds its line low four clocks, long enough to pass the synchroniser
  always @(posedge core_clk) begin
    for (int i = 0; i < 14; i++) begin
      if (pulse_req[i]) left[i] <= 3'h4;
      else if (left[i] != 3'h0) left[i] <= left[i] - 3'h1;
    end
    // Lid switch flips level; either direction is activity
    if (pulse_req[7]) lid_in <= ~lid_in;
  end

  // Lines are pulled up when no source drives them low
  always_comb for (int i = 0; i < 14; i++) pin_n[i] = (left[i] == 3'h0);
endmodule : agpe_event_src

//--- dv/agpe_block_test.sv
// Self-checking bench for the event status/enable bytes and power-level triggers
module agpe_block_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, srst, io_rd, io_wr, route, lid_in;
  logic [15:0] io_addr, gb, pb, tcnt;
  logic [7:0]  io_wdata, io_rdata, en0, en1, sl, sh, clr;
  logic [3:0]  tsel;
  logic [13:0] pulse_req, pin_n;
  logic        io_claim, c2p, c3p, gss, smi, irq;
  int          seed = 25;
  int          miscompares = 0;
  int          n_checks = 0;

  agpe_event_src src (.core_clk(core_clk), .pulse_req(pulse_req), .lid_in(lid_in),
                      .pin_n(pin_n));

  agpe_block dut (
    .core_clk(core_clk), .srst(srst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_claim(io_claim),
    .gp_event_block_base(gb), .processor_control_block_base(pb),
    .lid_in(lid_in), .ec_event_in_n(pin_n[6]), .usb_wake_in_n(pin_n[5]),
    .ring_in_n(pin_n[4]), .ring_driveback_n(pin_n[12]),
    .second_ring_in_n(pin_n[3]), .second_ring_driveback_n(pin_n[13]),
    .card_change_in_n(pin_n[2]), .req_in_n_a(pin_n[1]), .req_in_n_b(pin_n[0]),
    .spare_in_n(pin_n[11:8]), .thermal_freq_counter(tcnt),
    .thermal_group_select(tsel), .interrupt_route_select(route),
    .force_c2_pulse(c2p), .force_c3_pulse(c3p), .global_service_set(gss),
    .sci_smi(smi), .sci_irq13(irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: byte %h want %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag %b want %b", $time, got, exp);
    end
  endtask : chk1

  // Control interrupt is pending when any status bit meets its enable
  function automatic logic exp_pending(input logic [7:0] s0, e0, s1, e1);
    return (|(s0 & e0)) || (|(s1[4:0] & e1[4:0]));
  endfunction : exp_pending

  // One strobe cycle, then results land on the following edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic cl, c2, c3);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge core_clk);
    #1;
    io_rd = 1'b0;
    chk8(io_rdata, e);
    chk1(io_claim, cl);
    chk1(c2p, c2);
    chk1(c3p, c3);
  endtask : rd

  // Writes never fire a power-level trigger; only bit 7 of enable hi requests service
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    chk1(gss, (a == gb + 16'h0003) && d[7]);
    chk1(c2p | c3p, 1'b0);
  endtask : wr

  task automatic fire(input logic [13:0] m);
    @(posedge core_clk);
    #1;
    pulse_req = m;
    @(posedge core_clk);
    #1;
    pulse_req = 14'h0000;
    repeat (10) @(posedge core_clk);
    // Leave off the edge so a caller's next change cannot race the sampling
    #1;
  endtask : fire

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  // Whole sequence needs about 580 clocks; the 10000-clock limit allows some seventeen times that
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  initial begin
    srst = 1'b1;
    {io_rd, io_wr, route} = 3'h0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    pulse_req = 14'h0000;
    gb = {8'($random(seed)), 8'h40};
    pb = gb + 16'h0100;
    tcnt = 16'($random(seed));
    tsel = 4'h0;
    repeat (6) @(posedge core_clk);
    #1;
    srst = 1'b0;
    repeat (6) @(posedge core_clk);
    for (int i = 0; i < 8; i++) rd(gb + i, 8'h00, 1'b1, 1'b0, 1'b0);
    end_test("reset");
    // Each low-byte source alone: sticky, untouched by 0 writes, cleared by 1
    for (int i = 0; i < 8; i++) begin
      fire(14'h0001 << i);
      rd(gb, 8'h01 << i, 1'b1, 1'b0, 1'b0);
      wr(gb, ~(8'h01 << i));
      rd(gb, 8'h01 << i, 1'b1, 1'b0, 1'b0);
      wr(gb, 8'h01 << i);
      rd(gb, 8'h00, 1'b1, 1'b0, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      fire(14'h1000 << j);
      rd(gb, 8'h10 >> j, 1'b1, 1'b0, 1'b0);
      wr(gb, 8'h10 >> j);
    end
    for (int i = 0; i < 4; i++) begin
      fire(14'h0100 << i);
      rd(gb + 16'h1, 8'h01 << i, 1'b1, 1'b0, 1'b0);
      wr(gb + 16'h1, 8'h01 << i);
      rd(gb + 16'h1, 8'h00, 1'b1, 1'b0, 1'b0);
    end
    end_test("events");
    // Only the selected counter bit may raise the thermal flag
    for (int k = 0; k < 4; k++) begin
      tsel = 4'($random(seed));
      repeat (3) @(posedge core_clk);
      #1;
      tcnt = tcnt ^ (16'h0001 << (tsel + 4'h1));
      rd(gb + 16'h1, 8'h00, 1'b1, 1'b0, 1'b0);
      tcnt = tcnt ^ (16'h0001 << tsel);
      rd(gb + 16'h1, 8'h10, 1'b1, 1'b0, 1'b0);
      wr(gb + 16'h1, 8'h10);
    end
    end_test("thermal");
    rd(pb + 16'h4, 8'h00, 1'b1, 1'b1, 1'b0);
    rd(pb + 16'h5, 8'h00, 1'b1, 1'b0, 1'b1);
    wr(pb + 16'h4, 8'($random(seed)));
    wr(pb + 16'h5, 8'($random(seed)));
    for (int i = 4; i < 8; i++) wr(gb + i, 8'hFF);
    for (int i = 4; i < 8; i++) rd(gb + i, 8'h00, 1'b1, 1'b0, 1'b0);
    rd(gb + 16'h8, 8'h00, 1'b0, 1'b0, 1'b0);
    rd(gb - 16'h1, 8'h00, 1'b0, 1'b0, 1'b0);
    end_test("decode");
    // Set every flag, then clear random parts and vary enables and route
    fire(14'h3FFF);
    tcnt = tcnt ^ (16'h0001 << tsel);
    repeat (3) @(posedge core_clk);
    rd(gb, 8'hFF, 1'b1, 1'b0, 1'b0);
    rd(gb + 16'h1, 8'h1F, 1'b1, 1'b0, 1'b0);
    sl = 8'hFF;
    sh = 8'h1F;
    for (int n = 0; n < 16; n++) begin
      clr = 8'($random(seed));
      en0 = 8'($random(seed));
      en1 = 8'($random(seed));
      route = 1'($random(seed));
      wr(gb + {15'h0, n[0]}, clr);
      if (n[0]) sh = sh & ~clr & 8'h1F;
      else sl = sl & ~clr;
      wr(gb + 16'h2, en0);
      wr(gb + 16'h3, en1);
      rd(gb + 16'h2, en0, 1'b1, 1'b0, 1'b0);
      rd(gb + 16'h3, en1 & 8'h1F, 1'b1, 1'b0, 1'b0);
      rd(gb + 16'h1, sh, 1'b1, 1'b0, 1'b0);
      chk1(smi, exp_pending(sl, en0, sh, en1) && !route);
      chk1(irq, exp_pending(sl, en0, sh, en1) && route);
    end
    end_test("interrupt");
    stop_test();
  end
endmodule : agpe_block_test
